// file: pkg/memsys_pkg.sv
// Constants, types and shared layout for the program/data memory block
// Function
// - Program counter addresses program memory, variant sized
// - Any reset loads PC with reset vector
// - Enabled external edge branches unless stack full
// - Enabled timer overflow branches to own vector
// - Enabled time base overflow branches to vector
// - Table pointer gives low eight address bits
// - Current-page read takes upper bits from PC
// - Last-page read forces upper bits to one
// - Low byte to register, high byte held
// - Table instructions take two instruction cycles
// - High-byte register read-only, table reads update
// - Table address width matches program memory depth
// - Data memory is byte-wide RAM, variant sized
// - Special area at 00H, general area follows
// - Unused special locations read as 00H
// - Bit set and clear on data memory
// - Direct addressing reaches bank 0 only
// - Some special locations ignore writes
// - Stack full keeps flag, withholds acknowledge
// - Bank 1 only via second pointer pair
package memsys_pkg;
   // Program memory geometry, largest variant
   localparam int          PM_AW    = 12;
   localparam int          PM_W     = 15;
   localparam int          PM_DEPTH = 4096;
   localparam int          LOW_W    = 8;
   localparam logic [3:0]  PAGE_ONE = 4'hf;
   // Vector locations
   localparam logic [11:0] VEC_RESET = 12'h000;
   localparam logic [11:0] VEC_EXT   = 12'h004;
   localparam logic [11:0] VEC_TMR0  = 12'h008;
   localparam logic [11:0] VEC_TMR1  = 12'h00c;
   localparam logic [11:0] VEC_TBASE = 12'h010;
   // Data memory map
   localparam logic [6:0]  A_IND1  = 7'h00;
   localparam logic [6:0]  A_PTR1  = 7'h01;
   localparam logic [6:0]  A_IND2  = 7'h02;
   localparam logic [6:0]  A_PTR2  = 7'h03;
   localparam logic [6:0]  A_BANK  = 7'h04;
   localparam logic [6:0]  A_LHB   = 7'h05;
   localparam logic [6:0]  A_TPTR  = 7'h06;
   localparam logic [6:0]  A_GP    = 7'h20;
   localparam logic [6:0]  B1_TOP  = 7'h3f;
   localparam int          RAM_DEPTH = 128;
   localparam logic [6:0]  B1_BASE = 7'h60;
   localparam logic [7:0]  ZERO8   = 8'h00;
   // External edge select codes
   localparam logic [1:0]  EDGE_FALL = 2'h1;
   localparam logic [1:0]  EDGE_RISE = 2'h2;
   localparam logic [1:0]  EDGE_BOTH = 2'h3;

   typedef enum logic {ST_RUN = 1'b0, ST_TBL = 1'b1} tbl_state_t;

   // One data memory access from the core
   typedef struct packed {
      logic       req;
      logic       wr;
      logic       bit_op;
      logic       bit_val;
      logic [2:0] bit_idx;
      logic       indirect;
      logic       ptr2;
      logic [6:0] addr;
      logic [7:0] wdata;
   } data_req_t;

   // Table read command: destination is a direct address
   typedef struct packed {
      logic       req;
      logic       last;
      logic [6:0] dest;
   } tbl_req_t;

   // Interrupt sources, ext highest priority
   typedef struct packed {
      logic ext;
      logic tmr0;
      logic tmr1;
      logic tbase;
   } irq_t;
endpackage : memsys_pkg

// file: rtl/memsys.sv
// Program memory, table read path, interrupt vectoring and data RAM
`timescale 1ns/1ps
module memsys (
   // Clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   // Program memory load port
   input  wire logic                    prog_we,
   input  wire logic [11:0]             prog_addr,
   input  wire logic [14:0]             prog_data,
   // Core control
   input  wire logic                    pc_load,
   input  wire logic [11:0]             pc_value,
   input  wire logic                    stack_full,
   input  wire memsys_pkg::tbl_req_t    tbl_req,
   input  wire memsys_pkg::data_req_t   data_req,
   // Interrupt inputs
   input  wire logic                    ext_pin,
   input  wire logic [1:0]              ext_edge_sel,
   input  wire logic                    tmr0_ovf,
   input  wire logic                    tmr1_ovf,
   input  wire logic                    tbase_ovf,
   input  wire memsys_pkg::irq_t        irq_enable,
   // Results
   output logic [11:0]                  pc_q,
   output logic [14:0]                  instr_q,
   output logic [7:0]                   rdata_q,
   output logic [7:0]                   lookup_high_byte_q,
   output memsys_pkg::irq_t             irq_flag_q,
   output logic                         int_ack_q,
   output logic                         tbl_busy
);
   import memsys_pkg::*;

   logic [14:0] pmem_q [PM_DEPTH];
   logic [7:0]  ram_q [RAM_DEPTH];
   logic [7:0]  ram_d [RAM_DEPTH];
   tbl_state_t  state_q, state_d;
   tbl_req_t    tcmd_q, tcmd_d;
   logic [11:0] pc_d;
   logic [14:0] instr_d;
   logic        ack_d, pin_q;
   irq_t        flag_d, take;
   logic [11:0] taddr;
   logic [14:0] tword;
   logic [7:0]  ptr1_q, ptr1_d, ptr2_q, ptr2_d, bank_q, bank_d;
   // Table pointer sits in the special area beside the memory pointers
   logic [7:0]  tptr_q, tptr_d;
   logic [7:0]  rdata_d, lhb_d, rd_val, old_val, new_val;
   logic [6:0]  ea, widx;
   logic        eb, wen, rd_en;
   // Write target kept apart from the read address so each has one driver
   logic [6:0]  wa;
   logic        wb;
   logic        ext_ev, any_take;
   logic [11:0] vec;

   assign tbl_busy = logic'(state_q);

   // Program store written only by the load port
   always_ff @(posedge clock) begin
      if (prog_we) begin
         pmem_q[prog_addr] <= prog_data;
      end
   end

   // Table address: pointer low, page bits from PC or forced high
   always_comb begin
      taddr[7:0]  = tptr_q;
      taddr[11:8] = tcmd_q.last ? PAGE_ONE : pc_q[11:8];
      tword       = pmem_q[taddr];
   end

   // Edge detect on external pin, sampled synchronously
   always_comb begin
      unique case (ext_edge_sel)
         EDGE_FALL: ext_ev = pin_q & ~ext_pin;
         EDGE_RISE: ext_ev = ~pin_q & ext_pin;
         EDGE_BOTH: ext_ev = pin_q ^ ext_pin;
         default:   ext_ev = 1'b0;
      endcase
   end

   // Interrupt arbitration; a table start takes precedence, flags wait
   always_comb begin
      take     = irq_flag_q & irq_enable & {4{~stack_full}};
      any_take = (state_q == ST_RUN) && !tbl_req.req && (take != 4'h0);
      vec      = VEC_TBASE;
      if (take.ext) begin
         vec = VEC_EXT;
      end else if (take.tmr0) begin
         vec = VEC_TMR0;
      end else if (take.tmr1) begin
         vec = VEC_TMR1;
      end
      // Set wins over the acknowledge clear
      flag_d = irq_flag_q;
      if (any_take) begin
         if (take.ext) begin
            flag_d.ext = 1'b0;
         end else if (take.tmr0) begin
            flag_d.tmr0 = 1'b0;
         end else if (take.tmr1) begin
            flag_d.tmr1 = 1'b0;
         end else begin
            flag_d.tbase = 1'b0;
         end
      end
      flag_d = flag_d | {ext_ev, tmr0_ovf, tmr1_ovf, tbase_ovf};
      ack_d  = any_take;
   end

   // Sequencer: PC, fetch and the two-cycle table read
   always_comb begin
      state_d = state_q;
      tcmd_d  = tcmd_q;
      pc_d    = pc_q + 12'h001;
      instr_d = pmem_q[pc_q];
      lhb_d   = lookup_high_byte_q;
      unique case (state_q)
         ST_RUN: begin
            if (tbl_req.req) begin
               state_d = ST_TBL;
               tcmd_d  = tbl_req;
            end else if (any_take) begin
               pc_d = vec;
            end else if (pc_load) begin
               pc_d = pc_value;
            end
         end
         ST_TBL: begin
            // Dedicated access slot: no fetch, PC held
            state_d = ST_RUN;
            pc_d    = pc_q;
            instr_d = instr_q;
            lhb_d   = {1'b0, tword[PM_W-1:LOW_W]};
         end
      endcase
   end

   // Effective data address; bank 1 only through second pointer
   always_comb begin
      ea = data_req.addr;
      eb = 1'b0;
      if (data_req.indirect) begin
         ea = data_req.ptr2 ? ptr2_q[6:0] : ptr1_q[6:0];
         eb = data_req.ptr2 & bank_q[0];
      end
   end

   // Read value of a location; unused special addresses give 00H
   function automatic logic [7:0] peek(input logic [6:0] a, input logic b);
      peek = ZERO8;
      if (a >= A_GP) begin
         if (!b) begin
            peek = ram_q[7'(a - A_GP)];
         end else if (a <= B1_TOP) begin
            peek = ram_q[7'(a - A_GP + B1_BASE)];
         end
      end else if (a == A_PTR1) begin
         peek = ptr1_q;
      end else if (a == A_PTR2) begin
         peek = ptr2_q;
      end else if (a == A_BANK) begin
         peek = bank_q;
      end else if (a == A_LHB) begin
         peek = lookup_high_byte_q;
      end else if (a == A_TPTR) begin
         peek = tptr_q;
      end
   endfunction : peek

   // Data writes, bit operations and table low-byte store
   always_comb begin
      ram_d   = ram_q;
      ptr1_d  = ptr1_q;
      ptr2_d  = ptr2_q;
      bank_d  = bank_q;
      tptr_d  = tptr_q;
      rd_en   = data_req.req && !data_req.wr && !data_req.bit_op;
      rd_val  = peek(ea, eb);
      rdata_d = rd_en ? rd_val : rdata_q;
      old_val = rd_val;
      new_val = data_req.wdata;
      wa      = ea;
      wb      = eb;
      wen     = data_req.req && (data_req.wr || data_req.bit_op) && (state_q == ST_RUN);
      if (data_req.bit_op) begin
         new_val = old_val;
         new_val[data_req.bit_idx] = data_req.bit_val;
      end
      // Table slot owns the write port; a core write here is dropped
      if (state_q == ST_TBL) begin
         wa      = tcmd_q.dest;
         wb      = 1'b0;
         wen     = 1'b1;
         new_val = tword[LOW_W-1:0];
      end
      widx = 7'(wa - A_GP);
      if (wen && wa >= A_GP) begin
         if (!wb) begin
            ram_d[widx] = new_val;
         end else if (wa <= B1_TOP) begin
            ram_d[7'(widx + B1_BASE)] = new_val;
         end
      end else if (wen && wa == A_PTR1) begin
         ptr1_d = new_val;
      end else if (wen && wa == A_PTR2) begin
         ptr2_d = new_val;
      end else if (wen && wa == A_BANK) begin
         bank_d = new_val;
      end else if (wen && wa == A_TPTR) begin
         tptr_d = new_val;
      end
      // Indirect registers and high byte ignore writes
   end

   // State registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q            <= ST_RUN;
         tcmd_q             <= '0;
         pc_q               <= VEC_RESET;
         instr_q            <= '0;
         lookup_high_byte_q <= ZERO8;
         irq_flag_q         <= '0;
         int_ack_q          <= 1'b0;
         pin_q              <= 1'b0;
         rdata_q            <= ZERO8;
         ptr1_q             <= ZERO8;
         ptr2_q             <= ZERO8;
         bank_q             <= ZERO8;
         tptr_q             <= ZERO8;
         ram_q              <= '{default: ZERO8};
      end else begin
         state_q            <= state_d;
         tcmd_q             <= tcmd_d;
         pc_q               <= pc_d;
         instr_q            <= instr_d;
         lookup_high_byte_q <= lhb_d;
         irq_flag_q         <= flag_d;
         int_ack_q          <= ack_d;
         pin_q              <= ext_pin;
         rdata_q            <= rdata_d;
         ptr1_q             <= ptr1_d;
         ptr2_q             <= ptr2_d;
         bank_q             <= bank_d;
         tptr_q             <= tptr_d;
         ram_q              <= ram_d;
      end
   end

   // Checks
   sequence s_tbl_start;
      state_q == ST_RUN && tbl_req.req;
   endsequence

   sequence s_tbl_done;
      state_q == ST_TBL ##1 state_q == ST_RUN;
   endsequence

   a_reset_vector: assert property (@(posedge clock) disable iff (!rst_n)
      !$past(rst_n) |-> pc_q == VEC_RESET)
      else $error("PC not at reset vector after reset");
   a_ext_branch: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == ST_RUN && !tbl_req.req && take.ext |=> pc_q == VEC_EXT && int_ack_q)
      else $error("External interrupt did not vector");
   a_tmr_branch: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == ST_RUN && !tbl_req.req && !take.ext && take.tmr0 |=> pc_q == VEC_TMR0)
      else $error("Timer 0 interrupt did not vector");
   a_stack_hold: assert property (@(posedge clock) disable iff (!rst_n)
      stack_full |=> !int_ack_q)
      else $error("Acknowledge given while stack full");
   a_tbl_two_cyc: assert property (@(posedge clock) disable iff (!rst_n)
      s_tbl_start |=> s_tbl_done)
      else $error("Table read not two cycles");
   a_tbl_no_fetch: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == ST_TBL |=> pc_q == $past(pc_q) && $stable(instr_q))
      else $error("Fetch occurred in table cycle");
   a_last_page: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == ST_TBL && tcmd_q.last |-> taddr[11:8] == PAGE_ONE)
      else $error("Last page address not forced");
   a_high_byte: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == ST_TBL |=> lookup_high_byte_q == {1'b0, $past(tword[PM_W-1:LOW_W])})
      else $error("High byte not captured");
   a_lhb_readonly: assert property (@(posedge clock) disable iff (!rst_n)
      !$stable(lookup_high_byte_q) |-> $past(state_q) == ST_TBL)
      else $error("High byte changed outside table read");
   a_unused_zero: assert property (@(posedge clock) disable iff (!rst_n)
      rd_en && ea > A_TPTR && ea < A_GP |=> rdata_q == ZERO8)
      else $error("Unused special location not zero");
   // Guards on page forming, held flags and the busy slot
   a_cur_page: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == ST_TBL && !tcmd_q.last |-> taddr == {pc_q[11:8], tptr_q})
      else $error("Current page address not formed");
   a_flag_hold: assert property (@(posedge clock) disable iff (!rst_n)
      stack_full && irq_flag_q.tmr0 |=> irq_flag_q.tmr0)
      else $error("Flag lost while stack full");
   a_lhb_msb: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == ST_TBL |=> !lookup_high_byte_q[7])
      else $error("High byte top bit not zero");
   a_no_ack_busy: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == ST_TBL |=> !int_ack_q)
      else $error("Interrupt taken in table slot");
endmodule : memsys

// file: verif/core_model.sv
// Core-side model: program loads, jumps, data accesses and table reads
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // Requests toward the memory block
   output logic                       prog_we,
   output logic [11:0]                prog_addr,
   output logic [14:0]                prog_data,
   output logic                       pc_load,
   output logic [11:0]                pc_value,
   output memsys_pkg::tbl_req_t       tbl_req,
   output memsys_pkg::data_req_t      data_req
);
   import memsys_pkg::*;
   // Idle at time zero
   initial begin
      {prog_we, prog_addr, prog_data, pc_load, pc_value} = '0;
      tbl_req = '0;
      data_req = '0;
   end
   // Each request is held until the edge that takes it
   task automatic load(input logic [11:0] a, input logic [14:0] d);
      @(posedge clock);
      prog_we   <= 1'b1;
      prog_addr <= a;
      prog_data <= d;
      @(posedge clock);
      prog_we <= 1'b0;
   endtask : load
   task automatic jump(input logic [11:0] a);
      @(posedge clock);
      pc_load  <= 1'b1;
      pc_value <= a;
      @(posedge clock);
      pc_load <= 1'b0;
   endtask : jump
   task automatic access(input data_req_t r);
      @(posedge clock);
      data_req <= r;
      @(posedge clock);
      data_req.req <= 1'b0;
   endtask : access
   // Never issued while an interrupt is being raised, so the high byte stays ours
   task automatic table_read(input logic last, input logic [6:0] dest);
      @(posedge clock);
      tbl_req <= '{req: 1'b1, last: last, dest: dest};
      @(posedge clock);
      tbl_req.req <= 1'b0;
   endtask : table_read
endmodule : core_model

// file: verif/testbench.sv
// Self-checking bench for the memory block
`timescale 1ns/1ps
module testbench;
   import memsys_pkg::*;
   localparam logic [6:0] tptr_addr = 7'h06; // Table pointer location
   logic clock, rst_n, prog_we, pc_load, stack_full, ext_pin, tmr0_ovf, tmr1_ovf, tbase_ovf;
   logic [11:0] prog_addr, pc_value, pc_q;
   logic [14:0] prog_data, instr_q;
   logic [1:0]  ext_edge_sel;
   logic [7:0]  rdata_q, lookup_high_byte_q, ptr, d;
   logic        int_ack_q, tbl_busy, seen;
   tbl_req_t    tbl_req;
   data_req_t   data_req;
   irq_t        irq_enable, irq_flag_q;
   logic [14:0] w;
   logic [11:0] pcv;
   logic [6:0]  dest;
   int miscompares, checked, cycles;

   memsys memsys_i (.clock(clock), .rst_n(rst_n), .prog_we(prog_we),
      .prog_addr(prog_addr), .prog_data(prog_data), .pc_load(pc_load),
      .pc_value(pc_value), .stack_full(stack_full), .tbl_req(tbl_req),
      .data_req(data_req), .ext_pin(ext_pin), .ext_edge_sel(ext_edge_sel),
      .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf), .tbase_ovf(tbase_ovf),
      .irq_enable(irq_enable), .pc_q(pc_q), .instr_q(instr_q), .rdata_q(rdata_q),
      .lookup_high_byte_q(lookup_high_byte_q), .irq_flag_q(irq_flag_q),
      .int_ack_q(int_ack_q), .tbl_busy(tbl_busy));
   core_model core_model_i (.clock(clock), .rst_n(rst_n), .prog_we(prog_we),
      .prog_addr(prog_addr), .prog_data(prog_data), .pc_load(pc_load),
      .pc_value(pc_value), .tbl_req(tbl_req), .data_req(data_req));

   // 40 MHz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Hang guard, well above the few hundred cycles needed
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // Expected table address and high byte
   function automatic logic [11:0] tbl_addr(logic last, logic [11:0] pc, logic [7:0] p);
      return {(last ? 4'hf : pc[11:8]), p};
   endfunction : tbl_addr
   function automatic logic [7:0] hi(logic [14:0] x);
      return {1'b0, x[14:8]};
   endfunction : hi
   function automatic data_req_t mk(logic wr, logic ind, logic p2, logic bop, logic bv,
                                   logic [2:0] bi, logic [6:0] a, logic [7:0] v);
      return '{req: 1'b1, wr: wr, bit_op: bop, bit_val: bv, bit_idx: bi, indirect: ind,
               ptr2: p2, addr: a, wdata: v};
   endfunction : mk
   task automatic rd(input data_req_t r, input logic [7:0] exp, input string what);
      core_model_i.access(r);
      // A write is read back from the same place before comparing
      if (r.wr) begin
         r.wr = 1'b0;
         core_model_i.access(r);
      end
      @(posedge clock);
      #1;
      check(rdata_q, exp, what);
   endtask : rd
   // Raise one source, then watch a few cycles for the acknowledge
   task automatic fire(input int k, input logic exp, input logic [11:0] vec);
      @(posedge clock);
      case (k)
         0: ext_pin <= ~ext_pin;
         1: tmr0_ovf <= 1'b1;
         2: tmr1_ovf <= 1'b1;
         default: tbase_ovf <= 1'b1;
      endcase
      @(posedge clock);
      {tmr0_ovf, tmr1_ovf, tbase_ovf} <= 3'h0;
      wait_ack(exp, vec);
   endtask : fire
   task automatic wait_ack(input logic exp, input logic [11:0] vec);
      seen = 1'b0;
      repeat (5) begin
         #1;
         if (int_ack_q === 1'b1 && !seen) begin
            seen = 1'b1;
            pcv = pc_q;
         end
         @(posedge clock);
      end
      check(seen, exp, "ack");
      if (exp) check(pcv, vec, "vector");
   endtask : wait_ack

   initial begin
      {rst_n, stack_full, ext_pin, tmr0_ovf, tmr1_ovf, tbase_ovf} = '0;
      ext_edge_sel = EDGE_RISE;
      irq_enable = 4'hf;
      void'($urandom(18980));
      repeat (4) @(posedge clock);
      #1;
      check(pc_q, VEC_RESET, "reset pc");
      rst_n <= 1'b1;
      // Table reads, corner pointers then random ones
      for (int i = 0; i < 8; i++) begin
         ptr = (i == 0) ? 8'h00 : (i == 1) ? 8'hef : 8'($urandom_range(0, 239));
         for (int last = 0; last < 2; last++) begin
            w = 15'($urandom());
            dest = 7'($urandom_range(32, 127));
            pcv = tbl_addr(last[0], 12'h500, ptr);
            core_model_i.load(pcv, w);
            rd(mk(1, 0, 0, 0, 0, 0, tptr_addr, ptr), ptr, "ptr");
            core_model_i.jump(pcv);
            @(posedge clock);
            #1;
            check(instr_q, w, "fetch");
            if (!last) core_model_i.jump(12'h500);
            core_model_i.table_read(last[0], dest);
            #1;
            check(tbl_busy, 1'b1, "busy");
            @(posedge clock);
            #1;
            check(tbl_busy, 1'b0, "busy end");
            check(lookup_high_byte_q, hi(w), "high");
            rd(mk(0, 0, 0, 0, 0, 0, dest, 0), w[7:0], "low");
         end
      end
      // High byte place ignores writes
      rd(mk(1, 0, 0, 0, 0, 0, A_LHB, ~hi(w)), hi(w), "lhb wr");
      rd(mk(0, 0, 0, 0, 0, 0, A_LHB, 0), hi(w), "lhb");
      rd(mk(1, 0, 0, 0, 0, 0, 7'h10, 8'hff), 8'h00, "unused wr");
      rd(mk(0, 0, 0, 0, 0, 0, 7'h10, 0), 8'h00, "unused");
      d = 8'($urandom());
      rd(mk(1, 0, 0, 0, 0, 0, B1_TOP, d), d, "gp wr");
      rd(mk(0, 0, 0, 0, 0, 0, B1_TOP, 0), d, "gp");
      // Bit set one at a time, then clear all
      rd(mk(1, 0, 0, 0, 0, 0, A_GP, 0), 8'h00, "bit base");
      d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         d[i] = 1'b1;
         core_model_i.access(mk(1, 0, 0, 1, 1, 3'(i), A_GP, 0));
         rd(mk(0, 0, 0, 0, 0, 0, A_GP, 0), d, "bit set");
      end
      for (int i = 0; i < 8; i++) core_model_i.access(mk(1, 0, 0, 1, 0, 3'(i), A_GP, 0));
      rd(mk(0, 0, 0, 0, 0, 0, A_GP, 0), 8'h00, "bit clr");
      // Bank one only through the second pointer
      rd(mk(1, 0, 0, 0, 0, 0, 7'h25, 8'h3c), 8'h3c, "b0");
      rd(mk(1, 0, 0, 0, 0, 0, A_BANK, 8'h01), 8'h01, "bank");
      rd(mk(1, 0, 0, 0, 0, 0, A_PTR2, 8'h25), 8'h25, "p2");
      rd(mk(1, 1, 1, 0, 0, 0, 0, 8'hc3), 8'hc3, "b1 wr");
      rd(mk(0, 0, 0, 0, 0, 0, 7'h25, 0), 8'h3c, "direct");
      rd(mk(0, 1, 1, 0, 0, 0, 0, 0), 8'hc3, "indirect");
      // Interrupts: every edge kind, timers, time base
      fire(0, 1'b1, VEC_EXT);
      ext_edge_sel <= EDGE_FALL;
      fire(0, 1'b1, VEC_EXT);
      ext_edge_sel <= EDGE_BOTH;
      fire(0, 1'b1, VEC_EXT);
      ext_edge_sel <= EDGE_RISE;
      fire(0, 1'b0, VEC_EXT);
      check(irq_flag_q.ext, 1'b0, "ext flag");
      fire(1, 1'b1, VEC_TMR0);
      fire(2, 1'b1, VEC_TMR1);
      fire(3, 1'b1, VEC_TBASE);
      // Full stack keeps the flag and holds off the branch
      stack_full <= 1'b1;
      fire(1, 1'b0, VEC_TMR0);
      check(irq_flag_q.tmr0, 1'b1, "held flag");
      stack_full <= 1'b0;
      wait_ack(1'b1, VEC_TMR0);
      irq_enable.tmr1 <= 1'b0;
      fire(2, 1'b0, VEC_TMR1);
      irq_enable.tmr1 <= 1'b1;
      wait_ack(1'b1, VEC_TMR1);
      // Second reset in mid-run
      @(posedge clock);
      rst_n <= 1'b0;
      #1;
      check(pc_q, VEC_RESET, "rerun pc");
      check(lookup_high_byte_q, 8'h00, "rerun lhb");
      check(irq_flag_q, 4'h0, "rerun flags");
      // Release again and watch the first fetch step
      @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      check(pc_q, 12'h001, "resume pc");
      check(tbl_busy, 1'b0, "resume busy");
      print_verdict();
   end
endmodule : testbench
